// File: dv/printer_model.sv
// Printer model: readiness lines and a character sink that stalls.
// Assumes the bench picks which readiness line is off per record.
`timescale 1ns/1ns
module printer_model (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic rts_on,
	input  wire logic dtr_on,
	output logic      carrier_detect,
	output logic      set_ready,
	output logic      char_ready
);
	int seed = 32'h1b2c3d4e; // Own stall pattern
	// Readiness lines follow the bench-driven rts_on and dtr_on inputs
	assign carrier_detect = rts_on;
	assign set_ready      = dtr_on;
	// Random stalls, so a character must stand until taken
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			char_ready <= 1'b0;
		end else begin
			char_ready <= 1'($random(seed));
		end
	end
endmodule : printer_model

// File: dv/tb_top.sv
// Bench for the record framer: registers over AXI4-Lite, stream checked.
// Assumes the printer model sits on the character output.
`timescale 1ns/1ns
module tb_top;
	import record_pkg::*;
	logic clk = 0, rst_n = 0, rts = 1, dtr = 1;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata;
	logic awvalid = 0, wvalid = 0, bvalid, bready = 0, awready, wready;
	logic arvalid = 0, arready, rvalid, rready = 0, dcd, dsr, crdy;
	logic [1:0] bresp, rresp, resp;
	logic lamp, fault, irq;
	char_type co;
	int err_count = 0, n_tests = 0, seed = 32'h6a57e3fe;
	logic [7:0] txt [NFIELDS][MAXW]; // Field text
	logic [1:0] mk [NFIELDS];        // Mark per field
	logic [8:0] exp_q [$];           // {judge, char}
	logic [31:0] v;
	always #20 clk = ~clk;
	record_framer uut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .carrier_detect(dcd), .set_ready(dsr),
		.char_out(co), .char_ready(crdy), .alarm_lamp(lamp),
		.print_fault(fault), .irq(irq));
	printer_model pm (.clk(clk), .rst_n(rst_n), .rts_on(rts),
		.dtr_on(dtr), .carrier_detect(dcd), .set_ready(dsr),
		.char_ready(crdy));
	// One compare; mismatches are printed at once
	task automatic check(input logic [31:0] seen, input logic [31:0] ex);
		n_tests++;
		if (seen !== ex) begin
			err_count++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, ex);
		end
	endtask : check
	task automatic conclude;
		if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : conclude
	// Write: both channels offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ad, wd, ha, hw;
		ad = 0;
		wd = 0;
		@(posedge clk);
		awaddr <= a; awvalid <= 1; wdata <= d; wvalid <= 1;
		while (!(ad && wd)) begin
			@(negedge clk);
			ha = awvalid && awready;
			hw = wvalid && wready;
			@(posedge clk);
			if (ha) begin awvalid <= 0; ad = 1; end
			if (hw) begin wvalid <= 0; wd = 1; end
		end
		bready <= 1;
		do begin @(negedge clk); ha = bvalid; resp = bresp; @(posedge clk);
		end while (!ha);
		bready <= 0;
	endtask : wr
	// Read: address held until taken, then data awaited
	task automatic rd(input logic [7:0] a);
		logic h;
		@(posedge clk);
		araddr <= a; arvalid <= 1;
		do begin @(negedge clk); h = arready; @(posedge clk); end while (!h);
		arvalid <= 0; rready <= 1;
		do begin @(negedge clk); h = rvalid; v = rdata; resp = rresp;
			@(posedge clk); end while (!h);
		rready <= 0;
	endtask : rd
	function automatic int fw(input int f);
		return f == 0 ? 2 : f < 3 ? 8 : f < 19 ? 10 : f == 19 ? 16 :
			f == 20 ? 8 : 10;
	endfunction : fw
	// Watcher: every character taken is matched to the oldest note
	always @(posedge clk) if (rst_n && co.valid && crdy) begin
		if (exp_q.size() == 0) check(32'h1, 32'h0);
		else check({co.judge, co.data}, exp_q.pop_front());
		check(co.data >= 8'h20 && co.data < 8'h7f, 1);
	end
	// One record: notes expected text, starts, then checks alarm side
	task automatic rec(input logic [3:0] c, input logic r, input logic d,
			input logic al, input logic lp);
		logic [7:0] ch;
		for (int f = 0; f < NFIELDS; f++)
			for (int k = 0; k < fw(f); k++) begin
				ch = txt[f][k];
				if (k == fw(f) - 1) ch = mk[f] == 1 ? CH_H :
					mk[f] == 2 ? CH_L : CH_SP;
				else if (c[2:1] != 0 && f == 0)
					ch = c[2] ? CH_A : CH_C;
				if (c[2:1] != 0 && (f == 1 || f == 2))
					ch = k == 0 ? CH_0 : CH_SP;
				exp_q.push_back({f == 0 && k == 0, ch});
			end
		@(posedge clk);
		rts <= r; dtr <= d;
		wr(CTRL_OFS, {28'h0, c} | 32'h1);
		wr(CTRL_OFS, {28'h0, c} | 32'h1); // Ignored while busy
		v = 0;
		for (int i = 0; i < 3000 && !v[ST_DONE]; i++) rd(STATUS_OFS);
		// Done rises as the last character is offered, not when taken
		for (int i = 0; i < 200 && exp_q.size() != 0; i++) @(posedge clk);
		check(v[ST_DONE], 1);
		check(v[ST_ALARM], al);
		check({lamp, fault}, {lp, lp});
		check(irq, 1);
		check(exp_q.size(), 0);
		rd(CTRL_OFS);
		check(v[CTRL_START], 0);
		wr(STATUS_OFS, 32'h3);
		rd(STATUS_OFS);
		check(v[1:0], STATUS_RST);
		check(irq, 0);
	endtask : rec
	initial begin
		#(40 * 60000);
		err_count++;
		conclude();
	end
	// Main sequence: load fields, then one record per case
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1;
		for (int f = 0; f < NFIELDS; f++) begin
			for (int k = 0; k < MAXW; k++)
				txt[f][k] = 8'(8'h41 + ($random(seed) & 15));
			mk[f] = ($random(seed) & 32'h7fff) % 3;
			wr(FIELD_OFS, f);
			for (int n = 0; n < 4; n++)
				wr(8'(WORD0_OFS + 4 * n), {txt[f][4*n+3], txt[f][4*n+2],
					txt[f][4*n+1], txt[f][4*n]});
			wr(MARK_OFS, mk[f]);
		end
		rd(MARK_OFS);
		check(v[1:0], mk[NFIELDS-1]);
		wr(MASK_OFS, 32'h3);
		rec(4'h0, 1, 1, 0, 0);
		rec(4'h0, 0, 1, 1, 1);
		rec(4'h2, 1, 0, 1, 1);
		rec(4'h4, 1, 1, 0, 0);
		rec(4'h8, 0, 0, 0, 0);
		wr(STATE_OFS, 32'h0);
		check(resp, 2'h2);
		rd(8'h30);
		check({resp, v}, {2'h2, 32'h0});
		repeat (5) @(posedge clk);
		conclude();
	end
endmodule : tb_top

// File: shared/record_pkg.sv
// Shared constants and carrier types for the printer result record framer.
// Assumes one 25 MHz clock domain and an AXI4-Lite register slave.
package record_pkg;
	// Register byte offsets
	localparam logic [7:0] CTRL_OFS    = 8'h00; // Start, policy, device select
	localparam logic [7:0] STATUS_OFS  = 8'h04; // Sticky events, w1c
	localparam logic [7:0] MASK_OFS    = 8'h08; // Interrupt mask
	localparam logic [7:0] FIELD_OFS   = 8'h0c; // Field index select
	localparam logic [7:0] WORD0_OFS   = 8'h10; // Field chars 0..3
	localparam logic [7:0] WORD1_OFS   = 8'h14; // Field chars 4..7
	localparam logic [7:0] WORD2_OFS   = 8'h18; // Field chars 8..11
	localparam logic [7:0] WORD3_OFS   = 8'h1c; // Field chars 12..15
	localparam logic [7:0] MARK_OFS    = 8'h20; // Per-field NG marks
	localparam logic [7:0] STATE_OFS   = 8'h24; // Live state readback
	// Control bit positions
	localparam int CTRL_START   = 0; // Write 1 to send a record
	localparam int CTRL_CLR1    = 1; // Single-OK count increment applied
	localparam int CTRL_CLRALL  = 2; // Forced count clear executed
	localparam int CTRL_PCSEL   = 3; // Serial device select: 1 = PC
	// Status bit positions
	localparam int ST_DONE  = 0; // Record finished
	localparam int ST_ALARM = 1; // Printer readiness alarm
	localparam logic [1:0] STATUS_RST = 2'h0;
	// Record layout
	localparam int NFIELDS   = 22;
	localparam int MAXW      = 16;
	localparam int PCT_LAST  = 3;  // Field just past the last current monitor field (2)
	// Judgment letters, NG suffix letters, zero and pad space
	localparam logic [7:0] CH_C = 8'h43;
	localparam logic [7:0] CH_A = 8'h41;
	localparam logic [7:0] CH_H = 8'h48;
	localparam logic [7:0] CH_L = 8'h4c;
	localparam logic [7:0] CH_0 = 8'h30;
	localparam logic [7:0] CH_SP = 8'h20;
	// Marks per field
	typedef enum logic [1:0] {
		MARK_NONE = 2'b00,
		MARK_HIGH = 2'b01,
		MARK_LOW  = 2'b10
	} mark_type;
	// Character stream output
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       judge; // Marks the judgment character
	} char_type;
endpackage : record_pkg

// File: src/record_framer.sv
// Result record framer: fixed-width ASCII fields to a serial printer.
// Assumes a UART downstream that takes one character per char_ready.
`timescale 1ns/1ns
module record_framer (
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic [7:0]         s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [7:0]         s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	input  wire logic               carrier_detect,
	input  wire logic               set_ready,
	output record_pkg::char_type    char_out,
	input  wire logic               char_ready,
	output logic                    alarm_lamp,
	output logic                    print_fault,
	output logic                    irq
);
	import record_pkg::*;

	// All checks below share the one clock and drop out in reset
	default clocking main_cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// Field widths in listed order; the judgment char is field 0.
	function automatic logic [4:0] field_width(input logic [4:0] f);
		case (f)
			5'd0: field_width = 5'd2;            // Judgment
			5'd1, 5'd2: field_width = 5'd8;      // Current monitors
			5'd19: field_width = 5'd16;          // Tool type
			5'd20: field_width = 5'd8;           // Error number
			default: field_width = 5'd10;
		endcase
	endfunction : field_width

	// Fields forced to zero by a count clear: measured values only
	function automatic logic is_measured(input logic [4:0] f);
		is_measured = (f == 5'd1) || (f == 5'd2);
	endfunction : is_measured

	typedef enum logic [1:0] {
		IDLE  = 2'b00,
		CHECK = 2'b01,
		SEND  = 2'b10
	} state_type;

	// Field text store, up to 16 chars per field
	logic [7:0]  text_mem [NFIELDS][MAXW];
	logic [1:0]  mark_reg [NFIELDS];
	logic [4:0]  sel_reg, sel_next;           // Field index for writes
	logic [3:0]  ctrl_reg, ctrl_next;         // Policy and device bits
	logic [1:0]  status_reg, status_next;     // Sticky events
	logic [1:0]  mask_reg, mask_next;         // Interrupt mask
	state_type   state_reg, state_next;
	logic [4:0]  fld_reg, fld_next;           // Field being sent
	logic [4:0]  pos_reg, pos_next;           // Char within field
	logic        lamp_reg, lamp_next;
	char_type    out_reg, out_next;
	// Bus handshake state
	logic        aw_hold_reg, aw_hold_next;
	logic [7:0]  aw_addr_reg, aw_addr_next;
	logic        w_hold_reg, w_hold_next;
	logic [31:0] w_data_reg, w_data_next;
	logic        bvalid_reg, bvalid_next;
	logic [1:0]  bresp_reg, bresp_next;
	logic        rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0]  rresp_reg, rresp_next;
	logic        wr_go;                       // Both halves present
	logic        start_pulse;
	logic        done_evt;
	logic        alarm_evt;
	logic [7:0]  cur_char;
	logic [4:0]  cur_w;

	assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
	assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;
	assign wr_go = aw_hold_reg && w_hold_reg && !bvalid_reg;
	assign start_pulse = wr_go && (aw_addr_reg == CTRL_OFS)
		&& w_data_reg[CTRL_START];

	// Bus slave next state: address and data latched in either order
	always_comb begin
		aw_hold_next = aw_hold_reg;
		aw_addr_next = aw_addr_reg;
		w_hold_next  = w_hold_reg;
		w_data_next  = w_data_reg;
		bvalid_next  = bvalid_reg;
		bresp_next   = bresp_reg;
		rvalid_next  = rvalid_reg;
		rdata_next   = rdata_reg;
		rresp_next   = rresp_reg;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_next = 1'b1;
			aw_addr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_hold_next = 1'b1;
			w_data_next = s_axi_wdata;
		end
		if (wr_go) begin
			aw_hold_next = 1'b0;
			w_hold_next  = 1'b0;
			bvalid_next  = 1'b1;
			// Offsets above MARK_OFS answer SLVERR, STATE_OFS included
			bresp_next = (aw_addr_reg > MARK_OFS) ? 2'b10 : 2'b00;
		end else if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_next = 1'b1;
			rresp_next  = 2'b00;
			case (s_axi_araddr)
				CTRL_OFS:   rdata_next = {28'h0, ctrl_reg};
				STATUS_OFS: rdata_next = {30'h0, status_reg};
				MASK_OFS:   rdata_next = {30'h0, mask_reg};
				FIELD_OFS:  rdata_next = {27'h0, sel_reg};
				MARK_OFS:   rdata_next = {30'h0, mark_reg[sel_reg]};
				STATE_OFS:  rdata_next = {8'h0, 3'h0, pos_reg,
					3'h0, fld_reg, 6'h0, state_reg};
				default: begin
					rdata_next = 32'h0;
					rresp_next = 2'b10;
				end
			endcase
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
	end

	// Control, status and mask next values; event set beats w1c clear
	always_comb begin
		ctrl_next   = ctrl_reg;
		mask_next   = mask_reg;
		sel_next    = sel_reg;
		status_next = status_reg;
		if (wr_go) begin
			case (aw_addr_reg)
				CTRL_OFS:   ctrl_next = w_data_reg[3:0] & 4'he;
				MASK_OFS:   mask_next = w_data_reg[1:0];
				FIELD_OFS:  sel_next  = w_data_reg[4:0];
				STATUS_OFS: status_next = status_reg & ~w_data_reg[1:0];
				default: ;
			endcase
		end
		if (done_evt)
			status_next[ST_DONE] = 1'b1;
		if (alarm_evt)
			status_next[ST_ALARM] = 1'b1;
	end

	// Character chosen for the current field and position
	always_comb begin
		cur_w    = field_width(fld_reg);
		cur_char = text_mem[fld_reg][pos_reg[3:0]];
		if (fld_reg == 5'd0 && pos_reg == 5'd0) begin
			if (ctrl_reg[CTRL_CLRALL])
				cur_char = CH_A;
			else if (ctrl_reg[CTRL_CLR1])
				cur_char = CH_C;
		end else if ((ctrl_reg[CTRL_CLR1] || ctrl_reg[CTRL_CLRALL])
			&& is_measured(fld_reg) && pos_reg == 5'd0) begin
			cur_char = CH_0;
		end else if ((ctrl_reg[CTRL_CLR1] || ctrl_reg[CTRL_CLRALL])
			&& is_measured(fld_reg)) begin
			cur_char = CH_SP; // Zeroed value carries no NG suffix
		end else if (pos_reg == cur_w - 5'd1) begin
			// Last slot carries the NG suffix or a pad space
			case (mark_reg[fld_reg])
				MARK_HIGH: cur_char = CH_H;
				MARK_LOW:  cur_char = CH_L;
				default:   cur_char = CH_SP;
			endcase
		end
	end

	// Sequencer: check readiness, then walk fields in order
	always_comb begin
		state_next = state_reg;
		fld_next   = fld_reg;
		pos_next   = pos_reg;
		lamp_next  = lamp_reg;
		out_next   = out_reg;
		done_evt   = 1'b0;
		alarm_evt  = 1'b0;
		if (out_reg.valid && char_ready)
			out_next.valid = 1'b0;
		case (state_reg)
			IDLE: begin
				if (start_pulse) begin
					state_next = CHECK;
					fld_next   = 5'd0;
					pos_next   = 5'd0;
				end
			end
			CHECK: begin
				// PC selection skips the printer check, still ASCII
				if (!ctrl_reg[CTRL_PCSEL]
					&& (!carrier_detect || !set_ready)) begin
					lamp_next = 1'b1;
					alarm_evt = 1'b1;
				end else begin
					lamp_next = 1'b0;
				end
				state_next = SEND;
			end
			SEND: begin
				if (!out_reg.valid || char_ready) begin
					out_next.valid = 1'b1;
					out_next.data  = cur_char;
					out_next.judge = (fld_reg == 5'd0) && (pos_reg == 5'd0);
					if (pos_reg == cur_w - 5'd1) begin
						pos_next = 5'd0;
						if (fld_reg == 5'(NFIELDS - 1)) begin
							state_next = IDLE;
							done_evt   = 1'b1;
						end else begin
							fld_next = fld_reg + 5'd1;
						end
					end else begin
						pos_next = pos_reg + 5'd1;
					end
				end
			end
			default: state_next = IDLE;
		endcase
	end

	// Field text and mark store, written from the bus
	always_ff @(posedge clk) begin
		if (wr_go && aw_addr_reg >= WORD0_OFS
			&& aw_addr_reg <= WORD3_OFS && sel_reg < 5'(NFIELDS)) begin
			for (int b = 0; b < 4; b++) begin
				if (s_axi_wstrb[b] || 1'b1)
					text_mem[sel_reg][{aw_addr_reg[3:2], 2'(b)}]
						<= w_data_reg[8*b +: 8];
			end
		end
		if (wr_go && aw_addr_reg == MARK_OFS && sel_reg < 5'(NFIELDS))
			mark_reg[sel_reg] <= w_data_reg[1:0];
	end

	// State registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg   <= IDLE;
			fld_reg     <= 5'd0;
			pos_reg     <= 5'd0;
			lamp_reg    <= 1'b0;
			out_reg     <= '0;
			ctrl_reg    <= 4'h0;
			status_reg  <= STATUS_RST;
			mask_reg    <= 2'h0;
			sel_reg     <= 5'd0;
			aw_hold_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_hold_reg  <= 1'b0;
			w_data_reg  <= 32'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= 2'b00;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h0;
			rresp_reg   <= 2'b00;
		end else begin
			state_reg   <= state_next;
			fld_reg     <= fld_next;
			pos_reg     <= pos_next;
			lamp_reg    <= lamp_next;
			out_reg     <= out_next;
			ctrl_reg    <= ctrl_next;
			status_reg  <= status_next;
			mask_reg    <= mask_next;
			sel_reg     <= sel_next;
			aw_hold_reg <= aw_hold_next;
			aw_addr_reg <= aw_addr_next;
			w_hold_reg  <= w_hold_next;
			w_data_reg  <= w_data_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
			rvalid_reg  <= rvalid_next;
			rdata_reg   <= rdata_next;
			rresp_reg   <= rresp_next;
		end
	end

	assign char_out    = out_reg;
	assign alarm_lamp  = lamp_reg;
	assign print_fault = lamp_reg;
	assign irq         = |(status_reg & mask_reg);

	// Readiness off in CHECK lights the lamp next cycle
	AST_ALARM_SET: assert property (
		state_reg == CHECK && !ctrl_reg[CTRL_PCSEL]
		&& (!carrier_detect || !set_ready) |=> alarm_lamp && print_fault)
		else $error("alarm not raised");
	// Alarm still moves on into sending
	AST_NO_ABORT: assert property (
		state_reg == CHECK |=> state_reg == SEND)
		else $error("record aborted");
	// A record always begins with a readiness check
	AST_CHECK_FIRST: assert property (
		state_reg == IDLE && start_pulse |=> state_reg == CHECK)
		else $error("send without check");
	// Forced clear puts A in the judgment slot
	AST_JUDGE_A: assert property (
		state_reg == SEND && fld_reg == 5'd0 && pos_reg == 5'd0
		&& ctrl_reg[CTRL_CLRALL] && (!out_reg.valid || char_ready)
		|=> char_out.data == CH_A)
		else $error("judgment not A");
	// Single-OK increment puts C in the judgment slot
	AST_JUDGE_C: assert property (
		state_reg == SEND && fld_reg == 5'd0 && pos_reg == 5'd0
		&& ctrl_reg[CTRL_CLR1] && !ctrl_reg[CTRL_CLRALL]
		&& (!out_reg.valid || char_ready) |=> char_out.data == CH_C)
		else $error("judgment not C");
	// Positions never reach the field width
	AST_PAD_WIDTH: assert property (
		state_reg == SEND |-> pos_reg < field_width(fld_reg))
		else $error("field overrun");
	// A current monitor field is left after its eighth character
	AST_PCT_WIDTH: assert property (
		fld_reg == 5'd2 && $past(fld_reg) == 5'd1
		|-> $past(pos_reg) == 5'd7)
		else $error("current field width");
	// Tool type is left after its sixteenth character
	AST_TOOL_WIDTH: assert property (
		fld_reg == 5'd20 && $past(fld_reg) == 5'd19
		|-> $past(pos_reg) == 5'd15)
		else $error("tool type width");
	// Limit fields are left after their tenth character
	AST_LIMIT_WIDTH: assert property (
		fld_reg == 5'd6 && $past(fld_reg) == 5'd5
		|-> $past(pos_reg) == 5'd9)
		else $error("limit width");
	// High mark puts H in a field's last slot
	AST_SUFFIX_H: assert property (
		state_reg == SEND && fld_reg != 5'd0 && !is_measured(fld_reg)
		&& pos_reg == cur_w - 5'd1 && mark_reg[fld_reg] == MARK_HIGH
		&& (!out_reg.valid || char_ready) |=> char_out.data == CH_H)
		else $error("missing H suffix");
endmodule : record_framer
